// ---- core/bcl_config_loader.sv ----
// Configuration bitstream loader front end: mode selection, configuration
// clock generation, PROM addressing, byte capture and chain forwarding.
// Assumes the configuration clock pad returns its driven level on
// configClockIn in master modes, and the internal frame logic supplies
// the option bits and the end of configuration.
//
// Notes on behaviour
// - slave serial samples serial input on rise
// - slave serial chain output on next fall
// - mode 111 selects slave serial
// - preamble and overflow bits forwarded down chain
// - master serial drives clock, samples each rise
// - master serial chain output 1.5 periods late
// - fast option multiplies driven clock eightfold
// - mode 000 selects master serial
// - parallel drives address, latches byte, steps
// - bytes leave LSB first, 1.5 periods late
// - mode 100 counts address up from zero
// - mode 110 counts address down from 3FFFF
// - upper address driven once wide requested
// - upper bits count alike; always-wide ignores 18
// - first byte at end of first strobe
// - peripheral first byte on second rise
// - peripheral bytes every eighth rise
// - acknowledge high one period per byte
// - mode 011 selects synchronous peripheral
`timescale 1ns/100ps

module bcl_config_loader
	import bcl_pkg::*;
(
	// System clock, reset and clock enable
	input  wire logic                sys_clk,
	input  wire logic                rst_b,
	input  wire logic                clkEn,
	// Mode pins and configuration start/finish
	input  wire logic                modePin0,
	input  wire logic                modePin1,
	input  wire logic                modePin2,
	input  wire logic                initHigh,
	input  wire logic                configFinished,
	// Options taken from the bitstream by the frame logic
	input  wire logic                acceleratedClockOption,
	input  wire logic                wideAddressOption,
	// Configuration clock pad
	input  wire logic                configClockIn,
	output logic                     configClockOut,
	output logic                     configClockOe_b,
	// Serial and parallel configuration data
	input  wire logic                serialDataIn,
	input  wire logic [BYTE_W-1:0]   parallelConfigByte,
	// Configuration memory addressing
	output logic [ADDR_LOW_W-1:0]    promAddressLow,
	output logic [ADDR_UP_W-1:0]     promAddressUpper,
	output logic                     promAddressUpperOe_b,
	output logic                     readStrobe_b,
	// Handshake, chain and status
	output logic                     readyAck,
	output logic                     chainOut,
	output logic                     lowDuringConfig,
	// Assembled bytes to the frame logic
	output logic [BYTE_W-1:0]        configByte,
	output logic                     configByteValid
);

	// ------------------------------------------------------------
	// Mode decoding
	// ------------------------------------------------------------
	// Modes in which this device drives the configuration clock
	function automatic logic isMaster(input logic [2:0] m);
		isMaster = (m == MODE_MASTER_SERIAL) || (m == MODE_PAR_UP) ||
			(m == MODE_PAR_DOWN);
	endfunction : isMaster

	// Modes that take whole bytes rather than single bits
	function automatic logic isByteMode(input logic [2:0] m);
		isByteMode = (m == MODE_PAR_UP) || (m == MODE_PAR_DOWN) ||
			(m == MODE_SYNC_PERIPH);
	endfunction : isByteMode

	// Modes that address an external byte-wide memory
	function automatic logic isParallel(input logic [2:0] m);
		isParallel = (m == MODE_PAR_UP) || (m == MODE_PAR_DOWN);
	endfunction : isParallel

	// ------------------------------------------------------------
	// System domain state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0]        pinS1;
		logic [2:0]        pinS2;
		logic              initS1;
		logic              initS2;
		logic              initPrev;
		logic              togS1;
		logic              togS2;
		logic              togPrev;
		logic [2:0]        mode;
		logic              startPend;
		logic              active;
		logic [DIV_W-1:0]  divCnt;
		logic              clkLevel;
		logic              clkOe_b;
		logic              upperOe_b;
		logic              lowCfg;
		logic [BYTE_W-1:0] byteOut;
		logic              byteValid;
	} bcl_sys_type;

	// ------------------------------------------------------------
	// Link domain state
	// ------------------------------------------------------------
	typedef struct packed {
		logic                 actS1;
		logic                 actS2;
		logic                 enS1;
		logic                 enS2;
		logic [2:0]           modeS1;
		logic [2:0]           modeS2;
		bcl_link_state_type   state;
		logic [PHASE_W-1:0]   phase;
		logic [BYTE_W-1:0]    shift;
		logic [BYTE_W-1:0]    acc;
		logic [PHASE_W-1:0]   accCnt;
		logic                 pipeBit;
		logic                 chainBit;
		logic [BIT_CNT_W-1:0] bitCnt;
		logic [ADDR_W-1:0]    addr;
		logic                 strobe_b;
		logic                 ack;
		logic [BYTE_W-1:0]    xferByte;
		logic                 xferTog;
	} bcl_link_type;

	bcl_sys_type  sys_reg;
	bcl_sys_type  sys_next;
	bcl_link_type link_reg;
	bcl_link_type link_next;
	logic         chainFall;
	wire          linkRst_b = rst_b && sys_reg.active; // Idle link reset

	// ------------------------------------------------------------
	// System domain logic
	// ------------------------------------------------------------
	// Pin synchronisers, mode capture, clock divider, byte hand-over
	always_comb begin
		sys_next = sys_reg;
		sys_next.pinS1 = {modePin2, modePin1, modePin0};
		sys_next.pinS2 = sys_reg.pinS1;
		sys_next.initS1 = initHigh;
		sys_next.initS2 = sys_reg.initS1;
		sys_next.initPrev = sys_reg.initS2;
		sys_next.togS1 = link_reg.xferTog;
		sys_next.togS2 = sys_reg.togS1;
		sys_next.togPrev = sys_reg.togS2;
		sys_next.byteValid = 1'b0;
		// Capture the mode once, as configuration begins
		if (sys_reg.initS2 && !sys_reg.initPrev && !sys_reg.active) begin
			sys_next.mode = sys_reg.pinS2;
			sys_next.startPend = 1'b1;
		end
		// Raise active one cycle later so the mode has settled
		if (sys_reg.startPend) begin
			sys_next.startPend = 1'b0;
			sys_next.active = 1'b1;
		end
		if (configFinished) begin
			sys_next.active = 1'b0;
		end
		sys_next.lowCfg = !sys_next.active;
		// Drive the configuration clock only in master modes
		if (sys_reg.active && isMaster(sys_reg.mode)) begin
			sys_next.clkOe_b = 1'b0;
			if (sys_reg.divCnt >= (acceleratedClockOption ?
				FAST_HALF_LAST : SLOW_HALF_LAST)) begin
				sys_next.divCnt = '0;
				sys_next.clkLevel = !sys_reg.clkLevel;
			end else begin
				sys_next.divCnt = sys_reg.divCnt + DIV_ONE;
			end
		end else begin
			sys_next.clkOe_b = 1'b1;
			sys_next.divCnt = '0;
			sys_next.clkLevel = 1'b1;
		end
		// Upper address lines wake up on request or always-wide
		sys_next.upperOe_b = !(sys_reg.active &&
			isParallel(sys_reg.mode) &&
			(ALWAYS_WIDE_ADDR || wideAddressOption));
		// A toggle from the link side marks a new byte during a load
		if (sys_next.active && sys_reg.togS2 != sys_reg.togPrev) begin
			sys_next.byteOut = link_reg.xferByte;
			sys_next.byteValid = 1'b1;
		end
	end

	// System domain register; clock enable freezes everything
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sys_reg <= '{mode: MODE_SLAVE_SERIAL, clkLevel: 1'b1,
				clkOe_b: 1'b1, upperOe_b: 1'b1, lowCfg: 1'b1,
				default: '0};
		end else if (clkEn) begin
			sys_reg <= sys_next;
		end
	end

	// ------------------------------------------------------------
	// Link domain logic
	// ------------------------------------------------------------
	// Sequencing of bits and bytes on rising configuration clock edges
	always_comb begin
		logic passBit;
		logic outStep;
		logic latch;
		passBit = 1'b0;
		outStep = 1'b0;
		latch = 1'b0;
		link_next = link_reg;
		link_next.actS1 = sys_reg.active;
		link_next.actS2 = link_reg.actS1;
		link_next.enS1 = clkEn;
		link_next.enS2 = link_reg.enS1;
		link_next.modeS1 = sys_reg.mode;
		link_next.modeS2 = link_reg.modeS1;
		link_next.ack = 1'b0;
		if (link_reg.enS2) begin
			unique case (link_reg.state)
				LINK_IDLE: begin
					link_next.strobe_b = 1'b1;
					link_next.chainBit = 1'b1;
					link_next.bitCnt = '0;
					link_next.accCnt = '0;
					link_next.phase = '0;
					link_next.addr = (link_reg.modeS2 == MODE_PAR_DOWN) ?
						ADDR_DOWN_START : ADDR_UP_START;
					if (link_reg.actS2) begin
						link_next.state = LINK_FIRST;
						// Parallel memory read cycle opens here
						link_next.strobe_b =
							!isParallel(link_reg.modeS2);
					end
				end
				LINK_FIRST: begin
					// Second active edge: bytes latch, master primes pipe
					link_next.state = LINK_RUN;
					if (isByteMode(link_reg.modeS2)) begin
						latch = 1'b1;
					end else if (isMaster(link_reg.modeS2)) begin
						link_next.pipeBit = serialDataIn;
					end else begin
						outStep = 1'b1;
					end
				end
				LINK_RUN: begin
					outStep = 1'b1;
					if (isByteMode(link_reg.modeS2)) begin
						link_next.phase = link_reg.phase + PHASE_ONE;
						if (link_reg.phase == PHASE_READ) begin
							link_next.strobe_b =
								!isParallel(link_reg.modeS2);
						end
						if (link_reg.phase == PHASE_LATCH) begin
							latch = 1'b1;
						end
					end
				end
				default: begin
					link_next.state = LINK_IDLE;
				end
			endcase
			// Bit stream: serial input or byte shifter, LSB first
			if (outStep) begin
				unique case (link_reg.modeS2)
					MODE_SLAVE_SERIAL: begin
						passBit = serialDataIn;
					end
					MODE_MASTER_SERIAL: begin
						passBit = link_reg.pipeBit;
						link_next.pipeBit = serialDataIn;
					end
					default: begin
						passBit = link_reg.shift[0];
						link_next.shift = link_reg.shift >> 1;
					end
				endcase
				// Only preamble and overflow bits leave the chain
				link_next.chainBit = (link_reg.bitCnt < PREAMBLE_BITS) ||
					(link_reg.bitCnt >= OWN_CONFIG_BITS) ?
					passBit : 1'b1;
				if (link_reg.bitCnt != '1) begin
					link_next.bitCnt = link_reg.bitCnt + BIT_ONE;
				end
			end
			// Serial modes assemble bytes for the frame logic
			if (outStep && !isByteMode(link_reg.modeS2)) begin
				link_next.acc = {passBit, link_reg.acc[BYTE_W-1:1]};
				link_next.accCnt = link_reg.accCnt + PHASE_ONE;
				if (link_reg.accCnt == PHASE_LATCH) begin
					link_next.xferByte = link_next.acc;
					link_next.xferTog = !link_reg.xferTog;
				end
			end
			// Byte capture, address step and acknowledge
			if (latch) begin
				link_next.shift = parallelConfigByte;
				link_next.phase = '0;
				link_next.xferByte = parallelConfigByte;
				link_next.xferTog = !link_reg.xferTog;
				link_next.strobe_b = 1'b1;
				if (link_reg.modeS2 == MODE_PAR_UP) begin
					link_next.addr = link_reg.addr + ADDR_STEP;
				end else if (link_reg.modeS2 == MODE_PAR_DOWN) begin
					link_next.addr = link_reg.addr - ADDR_STEP;
				end
				link_next.ack =
					(link_reg.modeS2 == MODE_SYNC_PERIPH);
			end
			// Leaving configuration returns to idle
			if (!link_reg.actS2) begin
				link_next.state = LINK_IDLE;
				link_next.strobe_b = 1'b1;
			end
		end
	end

	// Link register, cleared outside a load since its clock may stop
	always_ff @(posedge configClockIn or negedge linkRst_b) begin
		if (!linkRst_b) begin
			link_reg <= '{state: LINK_IDLE, modeS1: MODE_SLAVE_SERIAL,
				modeS2: MODE_SLAVE_SERIAL, chainBit: 1'b1,
				strobe_b: 1'b1, default: '0};
		end else begin
			link_reg <= link_next;
		end
	end

	// ------------------------------------------------------------
	// Chain output on falling edges
	// ------------------------------------------------------------
	// Half a period after the rising-edge decision
	bcl_fall_reg u_chain_fall (
		.clk   (configClockIn),
		.rst_b (rst_b),
		.en    (link_reg.enS2),
		.d     (link_reg.chainBit),
		.q     (chainFall)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// All outputs come straight from registers
	assign configClockOut       = sys_reg.clkLevel;
	assign configClockOe_b      = sys_reg.clkOe_b;
	assign promAddressLow       = link_reg.addr[ADDR_LOW_W-1:0];
	assign promAddressUpper     = link_reg.addr[ADDR_W-1:ADDR_LOW_W];
	assign promAddressUpperOe_b = sys_reg.upperOe_b;
	assign readStrobe_b         = link_reg.strobe_b;
	assign readyAck             = link_reg.ack;
	assign chainOut             = chainFall;
	assign lowDuringConfig      = sys_reg.lowCfg;
	assign configByte           = sys_reg.byteOut;
	assign configByteValid      = sys_reg.byteValid;

endmodule : bcl_config_loader

// ---- core/bcl_fall_reg.sv ----
// Falling-edge output register for the serial chain output.
// Assumes clk is the configuration link clock and en is on that clock.
`timescale 1ns/100ps

module bcl_fall_reg (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Data
	input  wire logic en,
	input  wire logic d,
	output logic      q
);

	// ------------------------------------------------------------
	// Register
	// ------------------------------------------------------------
	// Chain output idles high and changes only on falling edges
	always_ff @(negedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= 1'b1;
		end else if (en) begin
			q <= d;
		end
	end

endmodule : bcl_fall_reg

// ---- core/bcl_pkg.sv ----
// Shared constants and types of the bitstream configuration loader.
// Assumes a 100 MHz system clock and a configuration clock pad that
// loops its driven level back into the link clock port.
package bcl_pkg;

	// ------------------------------------------------------------
	// Mode pin codes, read as {mode2, mode1, mode0}
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_MASTER_SERIAL = 3'b000,
		MODE_SYNC_PERIPH   = 3'b011,
		MODE_PAR_UP        = 3'b100,
		MODE_PAR_DOWN      = 3'b110,
		MODE_SLAVE_SERIAL  = 3'b111
	} bcl_mode_type;

	// ------------------------------------------------------------
	// Link-side sequencing states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		LINK_IDLE  = 2'b00,
		LINK_FIRST = 2'b01,
		LINK_RUN   = 2'b10
	} bcl_link_state_type;

	// ------------------------------------------------------------
	// Widths, addresses and stream lengths
	// ------------------------------------------------------------
	localparam int ADDR_W      = 22;
	localparam int ADDR_LOW_W  = 18;
	localparam int ADDR_UP_W   = 4;
	localparam int BYTE_W      = 8;
	localparam int PHASE_W     = 3;
	localparam int BIT_CNT_W   = 24;
	localparam int DIV_W       = 6;
	localparam logic [ADDR_W-1:0] ADDR_UP_START   = 22'h000000;
	localparam logic [ADDR_W-1:0] ADDR_DOWN_START = 22'h03FFFF;
	localparam logic [ADDR_W-1:0] ADDR_STEP       = 22'h000001;
	localparam logic [PHASE_W-1:0] PHASE_READ     = 3'h6;
	localparam logic [PHASE_W-1:0] PHASE_LATCH    = 3'h7;
	localparam logic [PHASE_W-1:0] PHASE_ONE      = 3'h1;
	localparam logic [BIT_CNT_W-1:0] BIT_ONE      = 24'h000001;
	localparam logic [BIT_CNT_W-1:0] PREAMBLE_BITS   = 24'h000028;
	localparam logic [BIT_CNT_W-1:0] OWN_CONFIG_BITS = 24'h001000;
	localparam logic ALWAYS_WIDE_ADDR = 1'b0;

	// ------------------------------------------------------------
	// Driven configuration clock timing
	// ------------------------------------------------------------
	localparam int SYS_PERIOD_NS  = 10;
	localparam int SLOW_PERIOD_NS = 800;
	localparam int FAST_FACTOR    = 8;
	localparam int SLOW_HALF_CYC  = SLOW_PERIOD_NS / (2 * SYS_PERIOD_NS);
	localparam int FAST_HALF_CYC  = SLOW_HALF_CYC / FAST_FACTOR;
	localparam logic [DIV_W-1:0] SLOW_HALF_LAST =
		DIV_W'(SLOW_HALF_CYC - 1);
	localparam logic [DIV_W-1:0] FAST_HALF_LAST =
		DIV_W'(FAST_HALF_CYC - 1);
	localparam logic [DIV_W-1:0] DIV_ONE = 6'h01;

endpackage : bcl_pkg

// ---- sim/bcl_partner.sv ----
// Far-side model: host clock, serial memory, byte memory or byte host.
// Assumes the bench fills mem and holds the mode during a load.
`timescale 1ns/100ps

module bcl_partner
	import bcl_pkg::*;
(
	// Mode, reset clocking and loader status
	input  wire logic [2:0]            mode,
	input  wire logic                  kick,
	input  wire logic                  lowDuringConfig,
	// Clock pad
	input  wire logic                  configClockOut,
	input  wire logic                  configClockOe_b,
	output logic                       configClockIn,
	// Memory side
	input  wire logic [ADDR_LOW_W-1:0] promAddressLow,
	input  wire logic                  readStrobe_b,
	output logic                       serialDataIn,
	output logic [BYTE_W-1:0]          parallelConfigByte
);
	logic [BYTE_W-1:0] mem [256];
	logic              hostClk = 1'b1;
	int                riseCnt = 0;
	int                j;
	logic              slave;

	assign slave = mode == 3'h7 || mode == 3'h3;
	assign j = riseCnt - 3;

	// Host clock runs while kick is high or within a slave-mode load, 32 ns period, own phase
	always begin
		if (kick || (slave && !lowDuringConfig)) begin
			#7 hostClk = 1'b0;
			#16 hostClk = 1'b1;
			#9;
		end else begin
			@(kick or lowDuringConfig or mode);
		end
	end

	// Pad level: the loader's own clock in master modes
	assign configClockIn = !configClockOe_b ? configClockOut : hostClk;

	// Rises of the current load; each advances the memory
	always @(posedge configClockIn or posedge lowDuringConfig) begin
		if (lowDuringConfig)
			riseCnt <= 0;
		else
			riseCnt <= riseCnt + 1;
	end

	// Memory disabled outside a load shows the host clock, toggling only while kick is high
	assign serialDataIn = lowDuringConfig ? hostClk : mem[j[10:3]][j[2:0]];
	assign parallelConfigByte = (mode == 3'h3) ? mem[j[10:3]] :
		readStrobe_b ? ~mem[promAddressLow[7:0]] : mem[promAddressLow[7:0]];
endmodule : bcl_partner

// ---- sim/bcl_sva.sv ----
// Port checker for the configuration loader.
// Assumes mode pins and options stay steady while a load runs.
`timescale 1ns/100ps

module bcl_sva
	import bcl_pkg::*;
(
	// Clocks and reset
	input wire logic                  sys_clk,
	input wire logic                  rst_b,
	input wire logic                  configClockIn,
	// Inputs watched
	input wire logic                  modePin0,
	input wire logic                  modePin1,
	input wire logic                  modePin2,
	input wire logic                  wideAddressOption,
	input wire logic                  acceleratedClockOption,
	// Outputs watched
	input wire logic                  configClockOut,
	input wire logic                  configClockOe_b,
	input wire logic [ADDR_LOW_W-1:0] promAddressLow,
	input wire logic                  promAddressUpperOe_b,
	input wire logic                  readStrobe_b,
	input wire logic                  readyAck,
	input wire logic                  chainOut,
	input wire logic                  lowDuringConfig,
	input wire logic                  configByteValid
);
	logic [2:0]       modeNow;
	logic [DIV_W-1:0] halfCnt;
	logic             clkPrev;
	logic             clkSeen;

	// Mode pins as one code
	assign modeNow = {modePin2, modePin1, modePin0};

	// Cycles since the driven clock last changed level
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			halfCnt <= '0;
			clkPrev <= 1'b1;
			clkSeen <= 1'b0;
		end else begin
			clkPrev <= configClockOut;
			halfCnt <= (clkPrev != configClockOut) ? '0 : halfCnt + DIV_ONE;
			clkSeen <= ((clkPrev != configClockOut) | clkSeen) & ~configClockOe_b;
		end
	end

	// ------------------------------------------------------------
	// Link side
	// ------------------------------------------------------------
	chk_ack_single_gap: assert property (
		@(posedge configClockIn) disable iff (!rst_b)
		$rose(readyAck) |=> !readyAck [*7])
		else $error("acknowledge width or spacing wrong");
	chk_ack_mode_only: assert property (
		@(posedge configClockIn) disable iff (!rst_b)
		readyAck |-> modeNow == 3'h3)
		else $error("acknowledge outside peripheral mode");
	chk_strobe_one: assert property (
		@(posedge configClockIn) disable iff (!rst_b)
		$fell(readStrobe_b) |=> readStrobe_b [*7])
		else $error("read strobe not one period per byte");
	chk_addr_up: assert property (
		@(posedge configClockIn) disable iff (!rst_b)
		$rose(readStrobe_b) && modeNow == 3'h4 |->
		promAddressLow == ADDR_LOW_W'($past(promAddressLow) + 1))
		else $error("upward address did not step by one");
	chk_addr_down: assert property (
		@(posedge configClockIn) disable iff (!rst_b)
		$rose(readStrobe_b) && modeNow == 3'h6 |->
		promAddressLow == ADDR_LOW_W'($past(promAddressLow) - 1))
		else $error("downward address did not step by one");

	// ------------------------------------------------------------
	// System side
	// ------------------------------------------------------------
	chk_clk_master: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		!configClockOe_b |-> modeNow inside {3'h0, 3'h4, 3'h6})
		else $error("clock driven in a slave mode");
	chk_clk_with_ldc: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		$fell(configClockOe_b) |-> !lowDuringConfig)
		else $error("clock driven outside configuration");
	chk_clk_half: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		clkPrev != configClockOut && clkSeen && !configClockOe_b |->
		halfCnt == (acceleratedClockOption ?
		FAST_HALF_LAST : SLOW_HALF_LAST))
		else $error("driven clock half period wrong");
	chk_upper_oe: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		!promAddressUpperOe_b |-> wideAddressOption)
		else $error("upper address driven without request");
	chk_chain_fall: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		$changed(chainOut) |-> !configClockIn)
		else $error("chain output moved off a falling edge");
	chk_valid_pulse: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		configByteValid |=> !configByteValid)
		else $error("byte valid longer than one cycle");

	// Main scenarios reached
	cov_ack: cover property (@(posedge configClockIn) $rose(readyAck));
	cov_strobe: cover property (@(posedge configClockIn) $fell(readStrobe_b));
	cov_fast: cover property (@(posedge sys_clk) halfCnt == FAST_HALF_LAST);
endmodule : bcl_sva

bind bcl_config_loader bcl_sva u_sva (
	.sys_clk, .rst_b, .configClockIn, .modePin0, .modePin1, .modePin2,
	.wideAddressOption, .acceleratedClockOption, .configClockOut,
	.configClockOe_b, .promAddressLow,
	.promAddressUpperOe_b, .readStrobe_b, .readyAck, .chainOut,
	.lowDuringConfig, .configByteValid
);

// ---- sim/tb_top.sv ----
// Self-checking bench: loads a stream in every mode and compares.
// Assumes the partner model drives the clock pad and memory side.
`timescale 1ns/100ps

module tb_top import bcl_pkg::*;;
	logic                  sys_clk = 1'b0;
	logic                  rst_b = 1'b0;
	logic                  clkEn = 1'b1;
	logic [2:0]            mode = 3'h7;
	logic                  initHigh = 1'b0;
	logic                  configFinished = 1'b0;
	logic                  accel = 1'b0;
	logic                  wide = 1'b0;
	logic                  kick = 1'b1;
	logic                  configClockIn;
	logic                  configClockOut;
	logic                  configClockOe_b;
	logic                  serialDataIn;
	logic [BYTE_W-1:0]     parallelConfigByte;
	logic [ADDR_LOW_W-1:0] promAddressLow;
	logic [ADDR_UP_W-1:0]  promAddressUpper;
	logic                  promAddressUpperOe_b;
	logic                  readStrobe_b;
	logic                  readyAck;
	logic                  chainOut;
	logic                  lowDuringConfig;
	logic [BYTE_W-1:0]     configByte;
	logic                  configByteValid;
	logic [BYTE_W-1:0]     eb;
	int                    errors = 0;
	int                    cmpCount = 0;
	int                    nb = 0;
	int                    jb;
	int                    nBytes = 12;

	bcl_config_loader dut (.sys_clk, .rst_b, .clkEn, .modePin0(mode[0]),
		.modePin1(mode[1]), .modePin2(mode[2]), .initHigh, .configFinished,
		.acceleratedClockOption(accel), .wideAddressOption(wide),
		.configClockIn, .configClockOut, .configClockOe_b, .serialDataIn,
		.parallelConfigByte, .promAddressLow, .promAddressUpper,
		.promAddressUpperOe_b, .readStrobe_b, .readyAck, .chainOut,
		.lowDuringConfig, .configByte, .configByteValid);
	bcl_partner p (.mode, .kick, .lowDuringConfig, .configClockOut,
		.configClockOe_b, .configClockIn, .promAddressLow, .readStrobe_b,
		.serialDataIn, .parallelConfigByte);

	// ------------------------------------------------------------
	// Clock, compare and verdict
	// ------------------------------------------------------------
	initial forever #5 sys_clk = ~sys_clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic close_out;
		$display("errors=%0d comparisons=%0d", errors, cmpCount);
		if (errors == 0 && cmpCount > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	// Expected byte k of the stream, from the memory and the count direction
	function automatic logic [7:0] expByte(input int k);
		return (mode == 3'h6) ? p.mem[8'hFF - k[7:0]] : p.mem[k[7:0]];
	endfunction : expByte

	// Byte model: every assembled byte and, in parallel modes, the address beside it
	always @(negedge sys_clk) begin
		if (rst_b && configByteValid) begin
			check(configByte, expByte(nb));
			if (mode == 3'h4)
				check(promAddressLow, nb + 1);
			if (mode == 3'h6)
				check(promAddressLow, 32'h3FFFF - nb - 1);
			if (mode[2] && !mode[0])
				check({promAddressUpperOe_b, promAddressUpper}, {!wide, 4'h0});
			nb++;
		end
	end

	// Chain model: preamble passes, the rest of the own length shows one
	always @(negedge configClockIn) begin
		#1;
		jb = p.riseCnt - ((mode == 3'h7) ? 4 : 5);
		if (!lowDuringConfig && jb >= 0 && jb < 8 * nBytes) begin
			eb = expByte(jb / 8);
			check(chainOut, (jb < 40) ? eb[jb % 8] : 1'b1);
		end
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic run(input logic [2:0] m, input logic a, input logic w);
		int t;
		mode = m;
		accel = a;
		wide = w;
		nb = 0;
		repeat (4) @(negedge sys_clk);
		initHigh = 1'b1;
		for (t = 0; t < 20000 && nb < nBytes; t++)
			@(negedge sys_clk);
		check(t < 20000, 1'b1);
		repeat (12) @(posedge configClockIn);
		@(negedge sys_clk);
		configFinished = 1'b1;
		initHigh = 1'b0;
		@(negedge sys_clk);
		configFinished = 1'b0;
		for (t = 0; t < 50 && !lowDuringConfig; t++)
			@(negedge sys_clk);
		check(lowDuringConfig, 1'b1);
		repeat (4) @(negedge sys_clk);
	endtask : run

	// Main sequence: reset values, then every mode in turn
	initial begin
		void'($urandom(64991));
		for (int i = 0; i < 256; i++)
			p.mem[i] = 8'($urandom);
		repeat (12) @(negedge sys_clk);
		check({lowDuringConfig, configClockOe_b, configClockOut, readStrobe_b,
			readyAck, chainOut, configByteValid, promAddressUpperOe_b},
			8'hF5);
		check(promAddressLow, 18'h00000);
		rst_b = 1'b1;
		@(negedge sys_clk);
		kick = 1'b0;
		// Frozen by the clock enable, a start request must go unseen
		clkEn = 1'b0;
		initHigh = 1'b1;
		repeat (6) @(negedge sys_clk);
		check(lowDuringConfig, 1'b1);
		clkEn = 1'b1;
		initHigh = 1'b0;
		run(3'h7, 1'b0, 1'b0);
		run(3'h0, 1'b1, 1'b0);
		run(3'h3, 1'b0, 1'b0);
		run(3'h4, 1'b0, 1'b0);
		run(3'h6, 1'b1, 1'b1);
		close_out;
	end

	// Watchdog well past the longest expected run
	initial begin
		#400000;
		errors++;
		close_out;
	end
endmodule : tb_top
